/* File: rtl/jtag_user_scan_consts.vh */
// Functional notes
// (RL1) Capture strobe high exactly while TAP is in Capture-DR.
// (RL2) Gated clock copies TCK only when selected and capturing or shifting.
// (RL3) Reset indication high while TAP is in Test-Logic-Reset.
// (RL4) Idle flag high while TAP is in Run-Test/Idle.
// (RL5) Select high only while the user instruction matching the chain number is active.
// (RL6) Shift strobe high while TAP is in Shift-DR.
// (RL7) TCK, TMS and TDI levels are forwarded unchanged to the fabric.
// (RL8) Fabric serial output captured on TCK falling edge, driven onto TDO when selected and in Shift-DR.
// (RL9) Update strobe high while TAP is in Update-DR.
// (RL10) Fabric should load its holding register on the update strobe rising edge.
// (RL11) Disable option, false by default, breaks the external chain.
// (RL12) Chain number picks one of four user instructions, values 1 to 4, default 1.
// (RL13) Four instances with distinct chain numbers serve all four user instructions.
// (RL14) Disable on the instance wins over any other enable request.
// (RL15) Port reaches only the primary die_region TAP.
// (RL16) Host holds TMS high five TCK cycles after power-up.
// (RL17) Without matching instruction, select stays low and TDO is not driven.
`ifndef JTAG_USER_SCAN_CONSTS_VH
`define JTAG_USER_SCAN_CONSTS_VH
`define TAP_RESET 4'h0
`define TAP_IDLE 4'h1
`define TAP_SEL_DR 4'h2
`define TAP_CAP_DR 4'h3
`define TAP_SHIFT_DR 4'h4
`define TAP_EXIT1_DR 4'h5
`define TAP_PAUSE_DR 4'h6
`define TAP_EXIT2_DR 4'h7
`define TAP_UPD_DR 4'h8
`define TAP_SEL_IR 4'h9
`define TAP_CAP_IR 4'ha
`define TAP_SHIFT_IR 4'hb
`define TAP_EXIT1_IR 4'hc
`define TAP_PAUSE_IR 4'hd
`define TAP_EXIT2_IR 4'he
`define TAP_UPD_IR 4'hf
`define IR_WIDTH 6
`define IR_RESET_VALUE 6'h09
`define IR_USER_ONE 6'h02
`define IR_USER_TWO 6'h03
`define IR_USER_THREE 6'h22
`define IR_USER_FOUR 6'h23
`endif

/* File: rtl/jtag_user_scan_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "jtag_user_scan_consts.vh"
module jtag_user_scan_port #(
  parameter CHAIN_NUMBER = 1,
  parameter DISABLE_JTAG = 0
) (
  input wire core_clk,
  input wire rst,
  input wire pin_tck,
  input wire pin_tms,
  input wire pin_tdi,
  output reg pin_tdo,
  output reg pin_tdo_oe,
  input wire user_tdo,
  output reg tck,
  output reg tms,
  output reg tdi,
  output reg capture,
  output reg shift,
  output reg update,
  output reg reset,
  output reg idle_state_flag,
  output reg sel,
  output reg gated_dr_clock
);
  reg [2:0] tck_sync;
  reg [1:0] tms_sync;
  reg [1:0] tdi_sync;
  reg [3:0] state;
  reg [3:0] next_state;
  reg [`IR_WIDTH-1:0] ir_shift;
  reg [`IR_WIDTH-1:0] ir;
  reg tdo_hold;
  wire tck_s = tck_sync[1];
  wire tck_rise = tck_sync[1] & ~tck_sync[2];
  wire tck_fall = ~tck_sync[1] & tck_sync[2];
  wire tms_s = tms_sync[1];
  wire tdi_s = tdi_sync[1];
  // Disable on the instance cannot be overridden (RL11, RL14)
  wire jtag_on = (DISABLE_JTAG == 0);

  function [`IR_WIDTH-1:0] user_code;
    input integer n;
    begin
      case (n)
        2: user_code = `IR_USER_TWO;
        3: user_code = `IR_USER_THREE;
        4: user_code = `IR_USER_FOUR;
        default: user_code = `IR_USER_ONE;
      endcase
    end
  endfunction

  // Single primary-die TAP only; one instruction per instance (RL15) (RL12)
  wire [`IR_WIDTH-1:0] my_code = user_code(CHAIN_NUMBER);
  wire selected = jtag_on && (ir == my_code); // RL5

  always @* begin
    next_state = state;
    case (state)
      `TAP_RESET: next_state = tms_s ? `TAP_RESET : `TAP_IDLE;
      `TAP_IDLE: next_state = tms_s ? `TAP_SEL_DR : `TAP_IDLE;
      `TAP_SEL_DR: next_state = tms_s ? `TAP_SEL_IR : `TAP_CAP_DR;
      `TAP_CAP_DR: next_state = tms_s ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
      `TAP_SHIFT_DR: next_state = tms_s ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
      `TAP_EXIT1_DR: next_state = tms_s ? `TAP_UPD_DR : `TAP_PAUSE_DR;
      `TAP_PAUSE_DR: next_state = tms_s ? `TAP_EXIT2_DR : `TAP_PAUSE_DR;
      `TAP_EXIT2_DR: next_state = tms_s ? `TAP_UPD_DR : `TAP_SHIFT_DR;
      `TAP_UPD_DR: next_state = tms_s ? `TAP_SEL_DR : `TAP_IDLE;
      `TAP_SEL_IR: next_state = tms_s ? `TAP_RESET : `TAP_CAP_IR;
      `TAP_CAP_IR: next_state = tms_s ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
      `TAP_SHIFT_IR: next_state = tms_s ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
      `TAP_EXIT1_IR: next_state = tms_s ? `TAP_UPD_IR : `TAP_PAUSE_IR;
      `TAP_PAUSE_IR: next_state = tms_s ? `TAP_EXIT2_IR : `TAP_PAUSE_IR;
      `TAP_EXIT2_IR: next_state = tms_s ? `TAP_UPD_IR : `TAP_SHIFT_IR;
      default: next_state = tms_s ? `TAP_SEL_DR : `TAP_IDLE;
    endcase
  end

  // Gate enable for the data-register clock, only changed while tck is low
  reg dr_gate;
  reg next_capture;
  reg next_shift;
  reg next_update;
  reg next_reset;
  reg next_idle;
  reg next_sel;
  reg next_gated;
  reg next_tdo;
  reg next_tdo_oe;

  function dr_scan_state;
    input [3:0] s;
    begin
      dr_scan_state = (s == `TAP_CAP_DR) || (s == `TAP_SHIFT_DR);
    end
  endfunction

  function in_shift_dr;
    input [3:0] s;
    begin
      in_shift_dr = (s == `TAP_SHIFT_DR);
    end
  endfunction

  // Pin synchronisers; tck keeps a third stage for edge detection
  always @(posedge core_clk) begin
    if (rst) begin
      tck_sync <= 3'h0;
      tms_sync <= 2'h3;
      tdi_sync <= 2'h0;
    end else begin
      tck_sync <= {tck_sync[1:0], pin_tck};
      tms_sync <= {tms_sync[0], pin_tms};
      tdi_sync <= {tdi_sync[0], pin_tdi};
    end
  end

  // Controller moves only on a detected tck rise; a disabled port stays in reset
  always @(posedge core_clk) begin
    if (rst) begin
      state <= `TAP_RESET;
    end else if (tck_rise && jtag_on) begin
      state <= next_state;
    end
  end

  // Instruction shifts in LSB first and becomes active at Update-IR
  always @(posedge core_clk) begin
    if (rst) begin
      ir_shift <= `IR_RESET_VALUE;
      ir <= `IR_RESET_VALUE;
    end else if (tck_rise && jtag_on) begin
      if (state == `TAP_RESET) begin
        ir <= `IR_RESET_VALUE;
      end else if (state == `TAP_UPD_IR) begin
        ir <= ir_shift;
      end
      if (state == `TAP_CAP_IR) begin
        ir_shift <= `IR_RESET_VALUE;
      end else if (state == `TAP_SHIFT_IR) begin
        ir_shift <= {tdi_s, ir_shift[`IR_WIDTH-1:1]};
      end
    end
  end

  // Falling-edge work: TDO timing register and the clock gate, so the gate
  // never opens while tck is high and the fabric sees no short pulse
  always @(posedge core_clk) begin
    if (rst) begin
      tdo_hold <= 1'b0;
      dr_gate <= 1'b0;
    end else if (tck_fall) begin
      tdo_hold <= user_tdo; // RL8
      dr_gate <= selected && dr_scan_state(state); // RL2
    end
  end

  // Decodes of the current state, registered below
  always @* begin
    next_capture = jtag_on && (state == `TAP_CAP_DR); // RL1
    next_shift = jtag_on && in_shift_dr(state); // RL6
    next_update = jtag_on && (state == `TAP_UPD_DR); // RL9
    next_reset = (state == `TAP_RESET); // RL3
    next_idle = jtag_on && (state == `TAP_IDLE); // RL4
    next_sel = selected; // RL5 RL17
    next_gated = tck_s && dr_gate; // RL2
    next_tdo_oe = selected && in_shift_dr(state); // RL17
    next_tdo = next_tdo_oe ? tdo_hold : 1'b0; // RL8 RL17
  end

  // Pin copies for the fabric
  always @(posedge core_clk) begin
    if (rst) begin
      tck <= 1'b0;
      tms <= 1'b1;
      tdi <= 1'b0;
    end else begin
      tck <= tck_s; // RL7
      tms <= tms_s; // RL7
      tdi <= tdi_s; // RL7
    end
  end

  // State strobes lag the controller state by one core cycle
  always @(posedge core_clk) begin
    if (rst) begin
      capture <= 1'b0;
      shift <= 1'b0;
      update <= 1'b0;
      reset <= 1'b1;
      idle_state_flag <= 1'b0;
      sel <= 1'b0;
      gated_dr_clock <= 1'b0;
    end else begin
      capture <= next_capture;
      shift <= next_shift;
      update <= next_update;
      reset <= next_reset;
      idle_state_flag <= next_idle;
      sel <= next_sel;
      gated_dr_clock <= next_gated;
    end
  end

  // TDO is held low whenever it is not enabled
  always @(posedge core_clk) begin
    if (rst) begin
      pin_tdo <= 1'b0;
      pin_tdo_oe <= 1'b0;
    end else begin
      pin_tdo <= next_tdo;
      pin_tdo_oe <= next_tdo_oe;
    end
  end
endmodule
`default_nettype wire

/* File: bench/scan_port_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module scan_port_sva #(parameter DISABLE_JTAG = 0) (input wire logic core_clk, rst, pin_tck,
  pin_tms, tck, tms, capture, shift, update, reset, idle_state_flag, sel, gated_dr_clock,
  pin_tdo, pin_tdo_oe);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence cap_rise; $rose(capture); endsequence
  a_tck_copy: assert property (tck == $past(pin_tck, 3)) else $error("tck copy");
  a_tms_copy: assert property (tms == $past(pin_tms, 3)) else $error("tms copy");
  a_one_state: assert property ($onehot0({capture, shift, update, reset, idle_state_flag}))
    else $error("state decode");
  a_cap_hold: assert property (cap_rise |-> capture[*4]) else $error("capture short");
  a_dr_sel: assert property (gated_dr_clock |-> sel) else $error("dr clock");
  a_oe_sel: assert property (pin_tdo_oe |-> sel) else $error("tdo enable");
  a_tdo_quiet: assert property (!pin_tdo_oe |-> !pin_tdo) else $error("tdo quiet");
  a_dis_hold: assert property (DISABLE_JTAG != 0 |-> reset && !sel) else $error("disable");
endmodule
bind jtag_user_scan_port scan_port_sva #(.DISABLE_JTAG(DISABLE_JTAG)) u_sva (.*);
`default_nettype wire

/* File: bench/fabric_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fabric_model (input wire logic gated_dr_clock, capture, update, tdi,
  output logic user_tdo, output logic [7:0] hold);
  logic [7:0] sreg = 8'h00;
  assign user_tdo = sreg[0];
  always @(posedge gated_dr_clock) sreg <= capture ? 8'ha5 : {tdi, sreg[7:1]};
  always @(posedge update) hold <= sreg;
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "jtag_user_scan_consts.vh"
module tb_top;
  logic core_clk = 0, rst = 1, pin_tck = 0, pin_tms = 1, pin_tdi = 0;
  wire pin_tdo, pin_tdo_oe, user_tdo, tck, tms, tdi, capture, shift, update, reset;
  wire idle_state_flag, sel, gated_dr_clock, dis_reset, dis_sel;
  wire [7:0] hold;
  int errors = 0, n_checks = 0, cyc = 0;
  always #5 core_clk = ~core_clk;
  jtag_user_scan_port #(.CHAIN_NUMBER(2)) u_dut (.*);
  jtag_user_scan_port #(.DISABLE_JTAG(1)) u_dis (.core_clk, .rst, .pin_tck, .pin_tms,
    .pin_tdi, .user_tdo(1'b0), .reset(dis_reset), .sel(dis_sel), .pin_tdo(), .pin_tdo_oe(),
    .tck(), .tms(), .tdi(), .capture(), .shift(), .update(), .idle_state_flag(),
    .gated_dr_clock());
  fabric_model u_fab (.*);
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One 125 ns link clock period, pins set ahead of the rising edge
  task automatic step(logic m, logic d);
    pin_tms = m;
    pin_tdi = d;
    #10 pin_tck = 1;
    #62.5 pin_tck = 0;
    #52.5;
  endtask
  task automatic load_ir(logic [5:0] code);
    logic [3:0] p = 4'b0011;
    for (int i = 0; i < 4; i++) step(p[i], 1'b0);
    for (int i = 0; i < 6; i++) step(i == 5, code[i]);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 5; i++) step(1'b1, 1'b0);
    check("reset", reset, 1);
    check("dis_reset", dis_reset, 1);
    step(1'b0, 1'b0);
    check("idle", idle_state_flag, 1);
  endtask
  task automatic t_codes();
    logic [5:0] c [4] = '{`IR_USER_ONE, `IR_USER_TWO, `IR_USER_THREE, `IR_USER_FOUR};
    for (int i = 0; i < 4; i++) begin
      load_ir(c[i]);
      check("sel", sel, c[i] == `IR_USER_TWO);
      check("dis_sel", dis_sel, 0);
    end
  endtask
  task automatic t_scan();
    logic [7:0] d = 8'h3c;
    logic [7:0] a = 8'ha5;
    load_ir(`IR_USER_TWO);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    check("capture", capture, 1);
    step(1'b0, 1'b0);
    check("shift", shift, 1);
    check("tdo_oe", pin_tdo_oe, 1);
    for (int i = 0; i < 8; i++) begin
      check("tdo", pin_tdo, a[i]);
      step(i == 7, d[i]);
      check("tdi", tdi, pin_tdi);
    end
    step(1'b1, 1'b0);
    check("update", update, 1);
    step(1'b0, 1'b0);
    check("hold", hold, d);
  endtask
  task report_and_stop();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    #1 rst = 0;
    #50;
    t_reset();
    t_codes();
    t_scan();
    report_and_stop();
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      report_and_stop();
    end
  end
endmodule
`default_nettype wire
